// [core/iee_defs.vh]
`ifndef IEE_DEFS_VH
`define IEE_DEFS_VH

// ==========================================================
// clock and timing
`define IEE_CLK_MHZ 125
// length of the modelled self-timed write cycle, in ns
`define IEE_WRITE_TIME_NS 100000
`define IEE_BUSY_W 20

// ==========================================================
// select byte layout
`define IEE_TYPE_ID 4'ha
`define IEE_TYPE_MSB 7
`define IEE_TYPE_LSB 4
`define IEE_CHIP_MSB 3
`define IEE_CHIP_LSB 1
`define IEE_RW_BIT 0

// ==========================================================
// byte position within a transfer, also the kind tag on the stream
`define IEE_KIND_SELECT 2'h0
`define IEE_KIND_ADDR_HI 2'h1
`define IEE_KIND_ADDR_LO 2'h2
`define IEE_KIND_DATA 2'h3

// ==========================================================
// bit counting, reset value and buffer full count
`define IEE_LAST_BIT 4'h7
`define IEE_FIRST_BIT_DONE 4'h1
`define IEE_SYNC_RST 6'h00
`define IEE_BUF_CNT_FULL 2'h2

`endif

// [core/iee_sync.v]
`include "iee_defs.vh"

module iee_sync #(
   parameter W = 6
) (
   // system
   input wire clock,
   input wire rstn,
   // asynchronous inputs and their filtered copies
   input wire [W-1:0] async_in,
   output wire [W-1:0] clean_out
);

   // ==========================================================
   // three-stage capture
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;
   reg [W-1:0] clean_reg;
   wire [W-1:0] clean_next;

   // a bit only moves once stages two and three agree
   assign clean_next = (s2_reg & s3_reg) | (clean_reg & (s2_reg ^ s3_reg));
   assign clean_out = clean_reg;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
         clean_reg <= {W{1'b0}};
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         clean_reg <= clean_next;
      end
   end

endmodule

// [core/iee_buf2.v]
`include "iee_defs.vh"

module iee_buf2 #(
   parameter W = 10
) (
   // system
   input wire clock,
   input wire rstn,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);

   // ==========================================================
   // two entries: head is always the word on offer
   reg [W-1:0] head_reg;
   reg [W-1:0] tail_reg;
   reg [1:0] cnt_reg;
   wire push;
   wire pop;

   assign in_ready = (cnt_reg != `IEE_BUF_CNT_FULL);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = head_reg;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         head_reg <= {W{1'b0}};
         tail_reg <= {W{1'b0}};
         cnt_reg <= 2'h0;
      end else begin
         if (pop) begin
            if (cnt_reg == `IEE_BUF_CNT_FULL) begin
               head_reg <= tail_reg;
            end else if (push) begin
               head_reg <= in_data;
            end
         end else if (push) begin
            if (cnt_reg == 2'h0) begin
               head_reg <= in_data;
            end else begin
               tail_reg <= in_data;
            end
         end
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

// [core/iee_slave.v]
// Function
// - respond only when select byte upper nibble is the type pattern 1010
// - select bits b3,b2,b1 must equal the three chip-select straps
// - an unconnected chip-select strap counts as logic zero
// - write-protect high keeps every write away from the array
// - unconnected write-protect reads low, writes permitted
// - write-protect high: ack select and address, not-ack every data byte
// - on write, ack each received byte in the ninth bit period; a byte arriving at a full stream buffer is not acked
// - start is data falling while clock stays high
// - outside write cycle, watch both lines, ignore traffic until start
// - stop is data rising while clock high; it ends communication
// - stop after a not-acked read byte returns device to standby
// - stop closing a write command launches the self-timed write cycle
// - transmitter releases data after eight bits; receiver pulls ninth low
// - data line only pulled low or released, never driven high
// - device is slave only; never starts transfers or makes the clock
// - while power-on reset is active, stay reset in standby
// - mismatched select byte: deselect, no ack, go to standby
// - write select followed by two address bytes, high byte first
// - only a stop right after a data-byte ack launches the write
// - during the write cycle keep data released and answer nothing
`include "iee_defs.vh"

module iee_slave #(
   parameter [31:0] WRITE_CYCLES = (`IEE_WRITE_TIME_NS * `IEE_CLK_MHZ) / 1000
) (
   // system
   input wire clock,
   input wire rstn,
   // bus lines
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   // straps, pads carry pull-downs
   input wire strap_select_bit0,
   input wire strap_select_bit1,
   input wire strap_select_bit2,
   input wire write_protect_in,
   // received address and data stream
   output wire wr_valid,
   input wire wr_ready,
   output wire [7:0] wr_data,
   output wire [1:0] wr_kind,
   // read data supply
   input wire [7:0] rd_data,
   output wire rd_take,
   // status
   output wire selected,
   output wire write_start,
   output wire busy
);

   // ==========================================================
   // states
   localparam [8:0] ST_IDLE = 9'h001;
   localparam [8:0] ST_RX = 9'h002;
   localparam [8:0] ST_ACKW = 9'h004;
   localparam [8:0] ST_ACKH = 9'h008;
   localparam [8:0] ST_TX = 9'h010;
   localparam [8:0] ST_TXEND = 9'h020;
   localparam [8:0] ST_MACK = 9'h040;
   localparam [8:0] ST_WAIT = 9'h080;
   localparam [8:0] ST_BUSY = 9'h100;

   localparam [`IEE_BUSY_W-1:0] BUSY_LAST =
      WRITE_CYCLES[`IEE_BUSY_W-1:0] - {{(`IEE_BUSY_W-1){1'b0}}, 1'b1};

   // ==========================================================
   // select byte match
   function match_select;
      input [7:0] sel_byte;
      input [2:0] straps;
      begin
         match_select =
            (sel_byte[`IEE_TYPE_MSB:`IEE_TYPE_LSB] == `IEE_TYPE_ID) &&
            (sel_byte[`IEE_CHIP_MSB:`IEE_CHIP_LSB] == straps);
      end
   endfunction

   // ==========================================================
   // line synchronisers
   wire [5:0] pins_clean;
   wire scl_s;
   wire sda_s;
   wire [2:0] strap_s;
   wire wp_s;

   // straps and write protect reset to zero, so floating pads read low
   iee_sync #(
      .W(6)
   ) u_sync (
      .clock(clock),
      .rstn(rstn),
      .async_in({write_protect_in, strap_select_bit2, strap_select_bit1,
                 strap_select_bit0, sda_in, scl_in}),
      .clean_out(pins_clean)
   );

   assign scl_s = pins_clean[0];
   assign sda_s = pins_clean[1];
   assign strap_s = pins_clean[4:2];
   assign wp_s = pins_clean[5];

   // ==========================================================
   // edges and conditions
   reg scl_d_reg;
   reg sda_d_reg;
   wire scl_rise;
   wire scl_fall;
   wire start_cond;
   wire stop_cond;

   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ==========================================================
   // state
   reg [8:0] state_reg;
   reg [8:0] state_next;
   reg [3:0] bit_cnt_reg;
   reg [3:0] bit_cnt_next;
   reg [7:0] shift_reg;
   reg [7:0] shift_next;
   reg [1:0] byte_idx_reg;
   reg [1:0] byte_idx_next;
   reg rw_reg;
   reg rw_next;
   reg ack_ok_reg;
   reg ack_ok_next;
   reg oe_reg;
   reg oe_next;
   reg data_acked_reg;
   reg data_acked_next;
   reg wp_lat_reg;
   reg wp_lat_next;
   reg sel_reg;
   reg sel_next;
   reg take_reg;
   reg take_next;
   reg wstart_reg;
   reg wstart_next;
   reg [`IEE_BUSY_W-1:0] busy_cnt_reg;
   reg [`IEE_BUSY_W-1:0] busy_cnt_next;
   reg push;
   reg [7:0] byte_in;
   reg byte_ok;

   wire buf_ready;
   wire [9:0] buf_out;

   // ==========================================================
   // next state
   always @* begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      byte_idx_next = byte_idx_reg;
      rw_next = rw_reg;
      ack_ok_next = ack_ok_reg;
      oe_next = oe_reg;
      data_acked_next = data_acked_reg;
      wp_lat_next = wp_lat_reg;
      sel_next = sel_reg;
      take_next = 1'b0;
      wstart_next = 1'b0;
      busy_cnt_next = busy_cnt_reg;
      push = 1'b0;
      byte_in = {shift_reg[6:0], sda_s};
      byte_ok = 1'b0;
      if (state_reg == ST_BUSY) begin
         // bus is ignored entirely until the count expires
         oe_next = 1'b0;
         if (busy_cnt_reg == BUSY_LAST) begin
            state_next = ST_IDLE;
            busy_cnt_next = {`IEE_BUSY_W{1'b0}};
         end else begin
            busy_cnt_next = busy_cnt_reg + {{(`IEE_BUSY_W-1){1'b0}}, 1'b1};
         end
      end else if (start_cond) begin
         // repeated start is legal from any state except ST_BUSY, which is handled first
         state_next = ST_RX;
         bit_cnt_next = 4'h0;
         byte_idx_next = `IEE_KIND_SELECT;
         oe_next = 1'b0;
         data_acked_next = 1'b0;
         wp_lat_next = wp_s;
         sel_next = 1'b0;
      end else if (stop_cond) begin
         oe_next = 1'b0;
         sel_next = 1'b0;
         data_acked_next = 1'b0;
         // the stop's own clock rise counted one bit of the next byte
         if (data_acked_reg && (state_reg == ST_RX) &&
             (bit_cnt_reg == `IEE_FIRST_BIT_DONE)) begin
            state_next = ST_BUSY;
            wstart_next = 1'b1;
            busy_cnt_next = {`IEE_BUSY_W{1'b0}};
         end else begin
            state_next = ST_IDLE;
         end
      end else begin
         case (state_reg)
            ST_RX: begin
               if (scl_rise) begin
                  shift_next = byte_in;
                  bit_cnt_next = bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == `IEE_FIRST_BIT_DONE) begin
                     data_acked_next = 1'b0;
                  end
                  // protect level is held from start to end of address
                  if (byte_idx_reg != `IEE_KIND_DATA) begin
                     wp_lat_next = wp_lat_reg | wp_s;
                  end
                  if (bit_cnt_reg == `IEE_LAST_BIT) begin
                     if (byte_idx_reg == `IEE_KIND_SELECT) begin
                        if (match_select(byte_in, strap_s)) begin
                           ack_ok_next = 1'b1;
                           rw_next = byte_in[`IEE_RW_BIT];
                           sel_next = 1'b1;
                           state_next = ST_ACKW;
                        end else begin
                           sel_next = 1'b0;
                           state_next = ST_IDLE;
                        end
                     end else begin
                        // a full buffer refuses the byte rather than lose it
                        byte_ok = buf_ready &
                           ((byte_idx_reg != `IEE_KIND_DATA) |
                            ~wp_lat_reg);
                        push = byte_ok;
                        ack_ok_next = byte_ok;
                        state_next = ST_ACKW;
                     end
                  end
               end
            end
            ST_ACKW: begin
               if (scl_fall) begin
                  oe_next = ack_ok_reg;
                  state_next = ST_ACKH;
               end
            end
            ST_ACKH: begin
               if (scl_fall) begin
                  bit_cnt_next = 4'h0;
                  if (!ack_ok_reg) begin
                     oe_next = 1'b0;
                     state_next = ST_WAIT;
                  end else if ((byte_idx_reg == `IEE_KIND_SELECT) &&
                               rw_reg) begin
                     shift_next = rd_data;
                     oe_next = ~rd_data[7];
                     take_next = 1'b1;
                     state_next = ST_TX;
                  end else begin
                     oe_next = 1'b0;
                     state_next = ST_RX;
                     data_acked_next = (byte_idx_reg == `IEE_KIND_DATA);
                     if (byte_idx_reg != `IEE_KIND_DATA) begin
                        byte_idx_next = byte_idx_reg + 2'h1;
                     end
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  oe_next = ~shift_reg[7];
               end else if (scl_rise) begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == `IEE_LAST_BIT) begin
                     state_next = ST_TXEND;
                  end
               end
            end
            ST_TXEND: begin
               if (scl_fall) begin
                  oe_next = 1'b0;
                  state_next = ST_MACK;
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  bit_cnt_next = 4'h0;
                  if (!sda_s) begin
                     shift_next = rd_data;
                     take_next = 1'b1;
                     state_next = ST_TX;
                  end else begin
                     state_next = ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               oe_next = 1'b0;
            end
            ST_IDLE: begin
               oe_next = 1'b0;
            end
            default: begin
               state_next = ST_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // registers, held in standby while power-on reset is low
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_idx_reg <= `IEE_KIND_SELECT;
         rw_reg <= 1'b0;
         ack_ok_reg <= 1'b0;
         oe_reg <= 1'b0;
         data_acked_reg <= 1'b0;
         wp_lat_reg <= 1'b0;
         sel_reg <= 1'b0;
         take_reg <= 1'b0;
         wstart_reg <= 1'b0;
         busy_cnt_reg <= {`IEE_BUSY_W{1'b0}};
         scl_d_reg <= 1'b0;
         sda_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         byte_idx_reg <= byte_idx_next;
         rw_reg <= rw_next;
         ack_ok_reg <= ack_ok_next;
         oe_reg <= oe_next;
         data_acked_reg <= data_acked_next;
         wp_lat_reg <= wp_lat_next;
         sel_reg <= sel_next;
         take_reg <= take_next;
         wstart_reg <= wstart_next;
         busy_cnt_reg <= busy_cnt_next;
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   // ==========================================================
   // stream buffer toward the memory side
   iee_buf2 #(
      .W(10)
   ) u_buf (
      .clock(clock),
      .rstn(rstn),
      .in_valid(push),
      .in_ready(buf_ready),
      .in_data({byte_idx_reg, byte_in}),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(buf_out)
   );

   // ==========================================================
   // outputs; scl is never driven, the block only listens to it
   assign wr_data = buf_out[7:0];
   assign wr_kind = buf_out[9:8];
   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign rd_take = take_reg;
   assign selected = sel_reg;
   assign write_start = wstart_reg;
   assign busy = (state_reg == ST_BUSY);

endmodule

// [verification/iee_slave_props.sv]
module iee_slave_props #(
   parameter [31:0] WRITE_CYCLES = 32'h30d4
) (
   // system
   input wire clock,
   input wire rstn,
   // bus
   input wire scl_in,
   input wire sda_out,
   input wire sda_oe,
   // stream and status
   input wire wr_valid,
   input wire wr_ready,
   input wire [7:0] wr_data,
   input wire [1:0] wr_kind,
   input wire rd_take,
   input wire selected,
   input wire write_start,
   input wire busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   // ==========================================================
   // length of the current busy run
   logic [31:0] busy_cnt;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         busy_cnt <= 32'h0;
      end else if (busy) begin
         busy_cnt <= busy_cnt + 32'h1;
      end else begin
         busy_cnt <= 32'h0;
      end
   end

   // ==========================================================
   // properties
   AST_OPEN_DRAIN: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("data line driven high");
   AST_PULL_IN_LOW: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data pulled while clock high");
   AST_QUIET_BUSY: assert property (busy |-> !sda_oe && !selected)
      else $error("bus answered during write cycle");
   AST_LAUNCH_BUSY: assert property (write_start |-> ##[0:1] busy)
      else $error("launch without busy");
   AST_LAUNCH_PULSE: assert property (write_start |=> !write_start)
      else $error("launch pulse too long");
   AST_BUSY_CAUSE: assert property ($rose(busy) |->
      write_start || $past(write_start))
      else $error("busy without launch");
   // the count holds the whole busy run at the edge where busy drops
   AST_BUSY_LEN: assert property ($fell(busy) |->
      busy_cnt == WRITE_CYCLES)
      else $error("write cycle length off");
   AST_READ_PACE: assert property (rd_take |=> !rd_take [*8])
      else $error("read bytes loaded too fast");
   AST_ACK_SELECTED: assert property ($rose(sda_oe) |-> ##[0:1] selected)
      else $error("pull without a match");
   AST_HEAD_HOLD: assert property (wr_valid && !wr_ready |=>
      wr_valid && $stable(wr_data) && $stable(wr_kind))
      else $error("stream head lost");

   COV_LAUNCH: cover property (write_start);
   COV_READ: cover property (rd_take);
   COV_STALL: cover property (wr_valid && !wr_ready);
   COV_DONE: cover property ($fell(busy));
endmodule

bind iee_slave iee_slave_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
   .clock(clock), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_data(wr_data), .wr_kind(wr_kind), .rd_take(rd_take),
   .selected(selected), .write_start(write_start), .busy(busy));

// [verification/iee_master.sv]
module iee_master #(
   parameter int H = 64
) (
   // bus lines
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // bus primitives; the clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic bit_cycle(input logic b, output logic s);
      #(H / 2);
      sda_low = ~b;
      #(H / 2);
      scl = 1'b1;
      #H;
      s = sda;
      scl = 1'b0;
   endtask
   task automatic start_cond;
      #(H / 2);
      sda_low = 1'b0;
      #(H / 2);
      scl = 1'b1;
      #H;
      sda_low = 1'b1;
      #H;
      scl = 1'b0;
   endtask
   task automatic stop_cond;
      #(H / 2);
      sda_low = 1'b1;
      #(H / 2);
      scl = 1'b1;
      #H;
      sda_low = 1'b0;
      #H;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d[i], s);
      end
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask
   task automatic recv_byte(input logic nak, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, s);
         d[i] = s;
      end
      bit_cycle(nak, s);
   endtask
endmodule

// [verification/testbench.sv]
`define CHK(nm, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) begin \
         n_mismatch++; \
         $display("wrong value %s expected %0h seen %0h", nm, e, g); \
      end \
   end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // long enough that a whole select byte fits inside the write cycle
   localparam int WCYC = 400;
   logic clock, rstn, scl, m_low, sda, sda_out, sda_oe, wp, wr_ready;
   logic wr_valid, rd_take, selected, write_start, busy;
   logic [2:0] straps;
   logic [7:0] wr_data, rd_data, rb;
   logic [1:0] wr_kind;
   logic [9:0] q[$];
   int n_mismatch = 0;
   int comparisons = 0;
   int n_ws = 0;
   int ws0;

   // open-drain wire with pull-up
   assign sda = ~m_low & ~(sda_oe & ~sda_out);
   iee_master #(.H(64)) mst (.scl(scl), .sda_low(m_low), .sda(sda));
   iee_slave #(.WRITE_CYCLES(WCYC)) dut (
      .clock(clock), .rstn(rstn), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_bit0(straps[0]),
      .strap_select_bit1(straps[1]), .strap_select_bit2(straps[2]),
      .write_protect_in(wp), .wr_valid(wr_valid), .wr_ready(wr_ready),
      .wr_data(wr_data), .wr_kind(wr_kind), .rd_data(rd_data),
      .rd_take(rd_take), .selected(selected), .write_start(write_start),
      .busy(busy));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      if (wr_valid && wr_ready) q.push_back({wr_kind, wr_data});
      if (write_start === 1'b1) n_ws++;
   end
   always @(negedge clock) begin
      if (rd_take === 1'b1) rd_data <= rd_data + 8'h01;
   end

   // ==========================================================
   // helpers
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic xfer(input logic [7:0] d, input logic e, input string nm);
      logic a;
      mst.send_byte(d, a);
      `CHK(nm, e, a)
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clock);
      if (busy !== 1'b0) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_write;
      ws0 = n_ws;
      mst.start_cond();
      xfer(8'haa, 1'b1, "select");
      xfer(8'h12, 1'b1, "address high");
      xfer(8'h34, 1'b1, "address low");
      xfer(8'h5c, 1'b1, "data");
      mst.stop_cond();
      `CHK("launch", 1, n_ws - ws0)
      `CHK("busy", 1'b1, busy)
      `CHK("stream", {10'h112, 10'h234, 10'h35c}, {q[0], q[1], q[2]})
      mst.start_cond();
      xfer(8'haa, 1'b0, "select while busy");
      mst.stop_cond();
      wait_idle();
      q.delete();
      $display("test write done");
   endtask
   task automatic t_straps;
      ws0 = n_ws;
      for (int s = 0; s < 8; s++) begin
         @(negedge clock);
         straps = s[2:0];
         repeat (8) @(negedge clock);
         mst.start_cond();
         xfer({4'ha, ~s[2:0], 1'b0}, 1'b0, "other straps");
         mst.start_cond();
         xfer({4'ha, s[2:0], 1'b0}, 1'b1, "own straps");
         xfer(8'h00, 1'b1, "address high");
         mst.stop_cond();
      end
      `CHK("no launch", 0, n_ws - ws0)
      @(negedge clock);
      straps = 3'b101;
      q.delete();
      $display("test straps done");
   endtask
   task automatic t_type;
      for (int b = 4; b < 8; b++) begin
         mst.start_cond();
         xfer(8'haa ^ (8'h01 << b), 1'b0, "type nibble");
         xfer(8'haa, 1'b0, "byte without start");
         mst.stop_cond();
      end
      `CHK("stream empty", 0, q.size())
      $display("test type done");
   endtask
   task automatic t_protect;
      int n;
      ws0 = n_ws;
      n = 0;
      @(negedge clock);
      wp = 1'b1;
      mst.start_cond();
      xfer(8'haa, 1'b1, "protected select");
      xfer(8'h00, 1'b1, "protected address");
      xfer(8'h40, 1'b1, "protected address");
      xfer(8'h77, 1'b0, "protected data");
      mst.stop_cond();
      `CHK("protected launch", 0, n_ws - ws0)
      foreach (q[i]) if (q[i][9:8] == 2'h3) n++;
      `CHK("protected stream", 0, n)
      @(negedge clock);
      wp = 1'b0;
      q.delete();
      $display("test protect done");
   endtask
   task automatic t_full;
      ws0 = n_ws;
      @(negedge clock);
      wr_ready = 1'b0;
      mst.start_cond();
      xfer(8'haa, 1'b1, "select");
      xfer(8'h21, 1'b1, "address high");
      xfer(8'h43, 1'b1, "address low");
      xfer(8'h65, 1'b0, "data into full buffer");
      mst.stop_cond();
      `CHK("full launch", 0, n_ws - ws0)
      `CHK("head", 11'h521, {wr_valid, wr_kind, wr_data})
      @(negedge clock);
      wr_ready = 1'b1;
      repeat (4) @(negedge clock);
      `CHK("drained", {10'h121, 10'h243}, {q[0], q[1]})
      `CHK("empty", 1'b0, wr_valid)
      q.delete();
      $display("test full done");
   endtask
   task automatic t_read;
      ws0 = n_ws;
      @(negedge clock);
      rd_data = 8'hc3;
      mst.start_cond();
      xfer(8'hab, 1'b1, "read select");
      mst.recv_byte(1'b0, rb);
      `CHK("read byte", 8'hc3, rb)
      mst.recv_byte(1'b1, rb);
      `CHK("last byte", 8'hc4, rb)
      mst.stop_cond();
      `CHK("standby", 1'b0, selected)
      `CHK("read launch", 0, n_ws - ws0)
      $display("test read done");
   endtask
   task automatic t_reset;
      mst.start_cond();
      xfer(8'haa, 1'b1, "select before reset");
      @(negedge clock);
      rstn = 1'b0;
      xfer(8'h12, 1'b0, "byte in reset");
      `CHK("idle in reset", 3'b000, {selected, sda_oe, busy})
      @(negedge clock);
      rstn = 1'b1;
      mst.stop_cond();
      mst.start_cond();
      xfer(8'haa, 1'b1, "select after reset");
      mst.stop_cond();
      $display("test reset done");
   endtask

   initial begin
      rstn = 1'b0;
      straps = 3'b101;
      wp = 1'b0;
      wr_ready = 1'b1;
      rd_data = 8'hc3;
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      repeat (8) @(negedge clock);
      t_write();
      t_straps();
      t_type();
      t_protect();
      t_full();
      t_read();
      t_reset();
      stop_test();
   end
endmodule
